// File: pct_dp_model.sv
// Behavioural timer datapath beside the control block: cycle ends and waveforms.
// Assumes it shares MCLK and runs only while the control block reports run.
`timescale 1ns/100ps
`default_nettype none
module pct_dp_model #(parameter int PERIOD = 20)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Run from the control block.
	input wire logic run,
	// Cycle end and raw waveforms.
	output logic cycle_end,
	output logic strobe,
	output logic out_a,
	output logic out_b
);
	int cnt;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst || !run)
			cnt <= 0;
		else
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
	end
	// A short period keeps deferred stops quick to observe.
	assign cycle_end = run && cnt == PERIOD - 1;
	assign out_a = run && cnt >= 5;
	assign out_b = run && cnt >= 8;
	assign strobe = run && cnt >= 12;
endmodule : pct_dp_model
`default_nettype wire

// File: pct_pkg.sv
// Constants for the timer one control block.
// Assumes the register sits at its documented address on the core's memory bus.
package pct_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'hAE;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int BIT_MODE = 7;
	localparam int BIT_EDGE_B = 6;
	localparam int BIT_OUT_A = 5;
	localparam int BIT_RUN = 4;
	localparam int BIT_PEND = 3;
	localparam int BIT_IRQ_EN = 2;
	localparam int BIT_UNUSED = 1;
	localparam int BIT_STROBE = 0;
	localparam int CNT_W = 12;
	localparam logic [11:0] CNT_ZERO = 12'h000;
	localparam logic [11:0] CNT_MAX = 12'hFFF;
	localparam logic [7:0] WR_MASK = 8'hFD;
	typedef enum logic [1:0] {ST_IDLE, ST_PWM, ST_STOPPING, ST_CAPTURE} pct_state_t;
endpackage : pct_pkg

// File: pct_sync.sv
// Two-stage synchroniser for an asynchronous pin input.
// Assumes the pin has no relation to MCLK.
`timescale 1ns/100ps
`default_nettype none
module pct_sync
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Pin level in and synchronised level out.
	pct_sync_if.snk s
);
	logic meta_ff;
	logic sync_ff;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end
		else
		begin
			meta_ff <= s.raw;
			sync_ff <= meta_ff;
		end
	end
	assign s.sync = sync_ff;
endmodule : pct_sync
`default_nettype wire

// File: pct_sync_if.sv
// Carrier between the control block and its pin synchroniser.
// Assumes one clock domain on the sampled side.
`timescale 1ns/100ps
`default_nettype none
interface pct_sync_if;
	logic raw;
	logic sync;
	modport src (output raw, input sync);
	modport snk (input raw, output sync);
endinterface : pct_sync_if
`default_nettype wire

// File: pct_timer_control.sv
// Control register, run/stop, capture flags and interrupt of timer one.
// Assumes the core writes with single-cycle strobes on MCLK; the datapath flags
// the end of each cycle; the period reload and capture edges are derived here.
`timescale 1ns/100ps
`default_nettype none
module pct_timer_control
	import pct_pkg::*;
(
	// Clock and reset.
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Register access from the core.
	input wire logic [7:0] ADDR,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	// Datapath status, same clock.
	input wire logic CYCLE_END,
	input wire logic PWM_STROBE,
	input wire logic PWM_OUT_A,
	input wire logic PWM_OUT_B,
	// Pins.
	input wire logic PIN_B_IN,
	input wire logic PORT_PIN_ONE_NORMAL,
	// Outputs.
	output logic [11:0] PERIOD_COUNTER,
	output logic COUNT_RUN,
	output logic CAPTURE_MODE,
	output logic CAPTURE_EVENT,
	output logic DRIVE_OUT_A,
	output logic DRIVE_OUT_B,
	output logic PORT_PIN_ONE,
	output logic TIMER_IRQ
);
	logic [7:0] ctrl_ff;
	logic [7:0] nxt_ctrl;
	logic [11:0] cnt_ff;
	logic [11:0] nxt_cnt;
	logic [7:0] rdata_ff;
	logic act_a_ff;
	logic act_b_ff;
	logic act_strobe_ff;
	logic act_edge_ff;
	logic prev_b_ff;
	logic irq_ff;
	logic capt_ff;
	logic run_ff;
	logic out_a_ff;
	logic out_b_ff;
	logic pin1_ff;
	pct_state_t state_ff;
	pct_state_t nxt_state;
	pct_sync_if sif ();
	pct_sync u_sync
	(
		.clk(MCLK),
		.rst(SYS_RST),
		.s(sif.snk)
	);
	assign sif.raw = PIN_B_IN;
	wire wr_hit = WR_EN && (ADDR == CTRL_ADDR);
	wire rd_hit = RD_EN && (ADDR == CTRL_ADDR);
	wire mode_cap = ctrl_ff[BIT_MODE];
	wire pin_b = sif.sync;
	// Edge sense uses the attribute in force, not the freshly written bit.
	wire rise_b = pin_b && !prev_b_ff;
	wire fall_b = !pin_b && prev_b_ff;
	wire capt_evt = (state_ff == ST_CAPTURE) && (act_edge_ff ? fall_b : rise_b);
	wire wrap_evt = (state_ff == ST_CAPTURE) && (cnt_ff == CNT_MAX);
	wire pwm_active = (state_ff == ST_PWM) || (state_ff == ST_STOPPING);
	wire reload_evt = pwm_active && CYCLE_END;
	wire running = pwm_active || (state_ff == ST_CAPTURE);
	// Attributes are latched at cycle end, or immediately while stopped.
	wire take_attr = !running || CYCLE_END;
	wire irq_src = mode_cap ? (ctrl_ff[BIT_PEND] || ctrl_ff[BIT_RUN])
		: ctrl_ff[BIT_PEND];
	wire irq_next = ctrl_ff[BIT_IRQ_EN] && irq_src;
	// The run bit reads as set until a deferred stop has really taken effect.
	wire run_seen = ctrl_ff[BIT_RUN] || (state_ff == ST_STOPPING);
	wire [7:0] rd_word = {ctrl_ff[7:5], run_seen, ctrl_ff[3:0]};

	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		nxt_state = state_ff;
		if (wr_hit)
		begin
			// Plain bits take the write; bit one is never stored.
			nxt_ctrl = (WDATA & WR_MASK);
			// Flags may only be cleared by software.
			nxt_ctrl[BIT_PEND] = ctrl_ff[BIT_PEND] & WDATA[BIT_PEND];
			if (mode_cap)
				nxt_ctrl[BIT_RUN] = ctrl_ff[BIT_RUN] & WDATA[BIT_RUN];
		end
		// Hardware sets win over a software clear in the same cycle.
		if (reload_evt || capt_evt)
			nxt_ctrl[BIT_PEND] = 1'b1;
		if (wrap_evt)
			nxt_ctrl[BIT_RUN] = 1'b1;
		case (state_ff)
			ST_IDLE:
			begin
				if (nxt_ctrl[BIT_MODE])
					nxt_state = ST_CAPTURE;
				else if (nxt_ctrl[BIT_RUN])
					nxt_state = ST_PWM;
			end
			ST_PWM:
			begin
				if (!nxt_ctrl[BIT_RUN] || nxt_ctrl[BIT_MODE])
					nxt_state = CYCLE_END ? ST_IDLE : ST_STOPPING;
			end
			ST_STOPPING:
			begin
				if (CYCLE_END)
					nxt_state = ST_IDLE;
			end
			ST_CAPTURE:
			begin
				// Leaving capture also waits for the cycle to finish.
				if (!nxt_ctrl[BIT_MODE] && CYCLE_END)
				begin
					nxt_state = ST_IDLE;
					nxt_ctrl[BIT_RUN] = 1'b0;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		// In PWM the run bit shows the stop taking effect at cycle end.
		if (!mode_cap && (state_ff == ST_STOPPING) && CYCLE_END)
			nxt_ctrl[BIT_RUN] = 1'b0;
	end

	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (nxt_state == ST_IDLE)
			nxt_cnt = CNT_ZERO;
		else if (state_ff == ST_IDLE)
			nxt_cnt = CNT_ZERO;
		else if (reload_evt)
			nxt_cnt = CNT_ZERO;
		else
			nxt_cnt = cnt_ff + 12'h001;
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			ctrl_ff <= CTRL_RESET;
			state_ff <= ST_IDLE;
			cnt_ff <= CNT_ZERO;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			act_a_ff <= 1'b0;
			act_b_ff <= 1'b0;
			act_strobe_ff <= 1'b0;
			act_edge_ff <= 1'b0;
		end
		else if (take_attr)
		begin
			// The word being written counts, so a start with new enables uses them at once.
			act_a_ff <= nxt_ctrl[BIT_OUT_A];
			act_b_ff <= nxt_ctrl[BIT_EDGE_B] && !nxt_ctrl[BIT_MODE];
			act_strobe_ff <= nxt_ctrl[BIT_STROBE];
			act_edge_ff <= nxt_ctrl[BIT_EDGE_B];
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			prev_b_ff <= 1'b0;
			irq_ff <= 1'b0;
			capt_ff <= 1'b0;
			run_ff <= 1'b0;
			out_a_ff <= 1'b0;
			out_b_ff <= 1'b0;
			pin1_ff <= 1'b0;
			rdata_ff <= CTRL_RESET;
		end
		else
		begin
			prev_b_ff <= pin_b;
			irq_ff <= irq_next;
			capt_ff <= capt_evt;
			run_ff <= (nxt_state != ST_IDLE);
			out_a_ff <= act_a_ff && running && PWM_OUT_A;
			out_b_ff <= act_b_ff && pwm_active && PWM_OUT_B;
			pin1_ff <= act_strobe_ff ? PWM_STROBE : PORT_PIN_ONE_NORMAL;
			// Readback is the stored word with run_seen as bit 4, not the attribute in force.
			rdata_ff <= rd_hit ? rd_word : 8'h00;
		end
	end

	// Software is trusted to use full loads, so no merge of a stale read is done.
	// Back-to-back events before a clear collapse into one flag.
	assign RDATA = rdata_ff;
	assign PERIOD_COUNTER = cnt_ff;
	assign COUNT_RUN = run_ff;
	assign CAPTURE_MODE = ctrl_ff[BIT_MODE];
	assign CAPTURE_EVENT = capt_ff;
	assign DRIVE_OUT_A = out_a_ff;
	assign DRIVE_OUT_B = out_b_ff;
	assign PORT_PIN_ONE = pin1_ff;
	assign TIMER_IRQ = irq_ff;

	property p_unused_zero;
		@(posedge MCLK) disable iff (SYS_RST)
		ctrl_ff[BIT_UNUSED] == 1'b0;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("Unused bit set.");

	property p_no_sw_set;
		@(posedge MCLK) disable iff (SYS_RST)
		(wr_hit && !ctrl_ff[BIT_PEND] && !reload_evt && !capt_evt) |=> !ctrl_ff[BIT_PEND];
	endproperty
	a_no_sw_set: assert property (p_no_sw_set) else $error("Pending set by write.");

	property p_pend_set;
		@(posedge MCLK) disable iff (SYS_RST)
		(reload_evt || capt_evt) |=> ctrl_ff[BIT_PEND];
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("Pending not set.");

	property p_wrap_set;
		@(posedge MCLK) disable iff (SYS_RST)
		(wrap_evt && !(ctrl_ff[BIT_MODE] && !nxt_ctrl[BIT_MODE] && CYCLE_END))
			|=> ctrl_ff[BIT_RUN];
	endproperty
	a_wrap_set: assert property (p_wrap_set) else $error("Wrap flag not set.");

	property p_irq_level;
		@(posedge MCLK) disable iff (SYS_RST)
		irq_next |=> TIMER_IRQ;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Interrupt not raised.");

	property p_irq_pwm;
		@(posedge MCLK) disable iff (SYS_RST)
		(!mode_cap && !ctrl_ff[BIT_PEND]) |=> !TIMER_IRQ;
	endproperty
	a_irq_pwm: assert property (p_irq_pwm) else $error("PWM interrupt without pending.");

	property p_reset_val;
		@(posedge MCLK) $fell(SYS_RST) |-> (ctrl_ff == CTRL_RESET);
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("Bad reset value.");

	property p_stop_defer;
		@(posedge MCLK) disable iff (SYS_RST)
		(state_ff == ST_PWM && !CYCLE_END) |=> (state_ff != ST_IDLE);
	endproperty
	a_stop_defer: assert property (p_stop_defer) else $error("Stop not deferred.");

	property p_start_zero;
		@(posedge MCLK) disable iff (SYS_RST)
		(state_ff == ST_IDLE) |=> (cnt_ff == CNT_ZERO);
	endproperty
	a_start_zero: assert property (p_start_zero) else $error("Counter not from zero.");
endmodule : pct_timer_control
`default_nettype wire

// File: tb_pwm_capture_timer_control.sv
// Self-checking bench for the timer one control block.
// Assumes the datapath model closes the loop on cycle ends.
`timescale 1ns/100ps
`default_nettype none
module tb_pwm_capture_timer_control;
	import pct_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} pct_row_t;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic pin_b = 1'b0;
	logic [7:0] rdata, rv;
	logic [11:0] cnt;
	logic run, cmode, cev, oa, ob, pin1, irq, cend, strb, ra, rb;
	logic seen_a, seen_b, seen_e;
	int err_count = 0;
	int total_checks = 0;
	pct_row_t rows [5] = '{'{CTRL_ADDR, 8'h65, 8'h65}, '{CTRL_ADDR, 8'h67, 8'h65},
		'{8'hAD, 8'h00, 8'h65}, '{CTRL_ADDR, 8'h0D, 8'h05}, '{CTRL_ADDR, 8'h01, 8'h01}};
	always #10 mclk = ~mclk;
	pct_timer_control DUT (.MCLK(mclk), .SYS_RST(rst), .ADDR(addr), .WR_EN(wr_en),
		.RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata), .CYCLE_END(cend), .PWM_STROBE(strb),
		.PWM_OUT_A(ra), .PWM_OUT_B(rb), .PIN_B_IN(pin_b), .PORT_PIN_ONE_NORMAL(1'b1),
		.PERIOD_COUNTER(cnt), .COUNT_RUN(run), .CAPTURE_MODE(cmode), .CAPTURE_EVENT(cev),
		.DRIVE_OUT_A(oa), .DRIVE_OUT_B(ob), .PORT_PIN_ONE(pin1), .TIMER_IRQ(irq));
	pct_dp_model dp (.clk(mclk), .rst(rst), .run(run), .cycle_end(cend), .strobe(strb),
		.out_a(ra), .out_b(rb));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Whole-register loads only, so no flag set mid-access is lost.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(posedge mclk);
		#1 wr_en = 1'b0;
	endtask : wr
	task automatic rd();
		@(posedge mclk);
		#1 addr = CTRL_ADDR;
		rd_en = 1'b1;
		@(posedge mclk);
		#1 rd_en = 1'b0;
		rv = rdata;
	endtask : rd
	task automatic wt(input logic sel);
		seen_a = 1'b0;
		seen_b = 1'b0;
		seen_e = 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge mclk);
			#1 seen_a |= oa;
			seen_b |= ob;
			seen_e |= cev;
			if (sel ? cev : cend)
				break;
		end
		@(posedge mclk);
		#1;
	endtask : wt
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	initial
	begin
		#400_000;
		err_count++;
		final_report();
	end
	initial
	begin
		repeat (16) @(posedge mclk);
		#1 rst = 1'b0;
		rd();
		chk(rv, CTRL_RESET);
		chk({run, irq, oa, ob, pin1}, 16'h0001);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			rd();
			chk(rv, rows[i].e);
		end
		chk(pin1, 1'b0);
		wr(CTRL_ADDR, 8'h34);
		wt(1'b0);
		chk(cnt, CNT_ZERO);
		chk({seen_a, seen_b}, 2'b10);
		rd();
		chk({rv, irq}, {8'h3C, 1'b1});
		wr(CTRL_ADDR, 8'h34);
		rd();
		chk({rv, irq}, {8'h34, 1'b0});
		wr(CTRL_ADDR, 8'h04);
		rd();
		chk(rv[BIT_RUN], 1'b1);
		wt(1'b0);
		chk(seen_a, 1'b1);
		rd();
		chk({rv[BIT_RUN], run, cnt}, {2'b00, CNT_ZERO});
		wr(CTRL_ADDR, 8'h84);
		repeat (4) @(posedge mclk);
		#1 pin_b = 1'b1;
		wt(1'b1);
		chk(seen_e, 1'b1);
		rd();
		chk({rv, irq}, {8'h8C, 1'b1});
		wr(CTRL_ADDR, 8'h94);
		pin_b = 1'b0;
		wt(1'b1);
		rd();
		chk({seen_e, rv, irq}, {1'b0, 8'h84, 1'b0});
		for (int i = 0; i < 5000 && cnt !== CNT_MAX; i++)
		begin
			@(posedge mclk);
			#1;
		end
		repeat (3) @(posedge mclk);
		rd();
		chk({rv, irq}, {8'h94, 1'b1});
		final_report();
	end
endmodule : tb_pwm_capture_timer_control
`default_nettype wire
